// [hw/sixteen_bit_timer_counter.sv]
/*
  Sixteen-bit up-counter with 1:1..1:8 prescaler, internal (Fosc/4) or
  external/secondary-oscillator source, optional buffered 16-bit access,
  overflow interrupt and secondary-clock power-state tracking.
  Assumes: mclk_i is Fosc at 40 MHz; the core drives one-cycle strobes and
  takes read data in the cycle after the read strobe; pins are asynchronous.

*/
`timescale 1ns/1ps
`default_nettype none

module sixteen_bit_timer_counter
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic     mclk_i,
  input  wire logic     resetn_i,
  // core register port
  input  wire reg_req_t bus_req_i,
  output logic [7:0]    bus_rdata_o,
  // core power events
  input  wire logic     sleep_exec_i,
  input  wire logic     wake_i,
  // oscillator pins: bit 0 osc_input_pin, bit 1 osc_output_ext_clock_pin
  input  wire logic [1:0] osc_pins_in_i,
  output logic [1:0]    osc_pins_out_o,
  output logic [1:0]    osc_pins_oe_n_o,
  // clocking and interrupt
  output logic          osc_running_o,
  output logic          cpu_clk_secondary_o,
  output logic          periph_clk_secondary_o,
  output logic          cpu_halted_o,
  output logic          irq_o
);

  // control state
  logic [7:0]   timer_control;
  logic [7:0]   oscillator_control;
  logic [1:0]   port_a_direction;
  logic [1:0]   pin_out_data;
  logic         overflow_flag;
  logic         overflow_irq_enable;
  logic [15:0]  count;
  logic [7:0]   high_buffer;
  logic [2:0]   presc;
  logic [1:0]   instr_div;
  logic         sync_pending;
  logic [7:0]   rdata;
  power_state_t pstate;
  power_state_t next_pstate;

  // pin synchronisers; stage 1 feeds only stage 2
  logic [1:0]   pin_s1;
  logic [1:0]   pin_s2;
  logic         src_prev;

  // field decode
  wire       counter_run          = timer_control[CTL_RUN_BIT];
  wire       source_select        = timer_control[CTL_SRC_BIT];
  wire       ext_input_sync_bypass = timer_control[CTL_SYNC_BYP_BIT];
  wire       low_power_osc_enable = timer_control[CTL_OSC_EN_BIT];
  wire [1:0] input_prescale_select = timer_control[CTL_PRESC_LO_BIT +: 2];
  wire       wide_access_enable   = timer_control[CTL_WIDE_BIT];
  wire [1:0] system_clock_select  = oscillator_control[OSC_SCS_LO_BIT +: 2];
  wire       idle_on_sleep        = oscillator_control[OSC_IDLE_BIT];
  wire       secondary_clock_active = (pstate != PRIMARY_RUN);

  // address decode
  wire wr_ctl   = bus_req_i.we && (bus_req_i.addr == REG_TIMER_CONTROL);
  wire wr_low   = bus_req_i.we && (bus_req_i.addr == REG_COUNT_LOW);
  wire wr_high  = bus_req_i.we && (bus_req_i.addr == REG_COUNT_HIGH);
  wire wr_mask  = bus_req_i.we && (bus_req_i.addr == REG_IRQ_MASK);
  wire wr_osc   = bus_req_i.we && (bus_req_i.addr == REG_OSC_CONTROL);
  wire wr_pins  = bus_req_i.we && (bus_req_i.addr == REG_PORT_PINS);
  wire rd_low   = bus_req_i.re && (bus_req_i.addr == REG_COUNT_LOW);
  wire rd_stat  = bus_req_i.re && (bus_req_i.addr == REG_IRQ_STATUS);

  // instruction-cycle strobe, one mclk in four
  wire instr_tick = (instr_div == INSTR_DIV_LAST);

  // edge source: secondary oscillator when enabled, else external clock pin
  wire src_level = low_power_osc_enable ? pin_s2[0] : pin_s2[1];
  wire src_rise  = src_level && !src_prev;

  // synchronised mode aligns edges to the instruction cycle; bypass takes them at once
  wire ext_tick  = ext_input_sync_bypass ? src_rise : (instr_tick && (sync_pending || src_rise));

  // internal source ignores the bypass bit
  wire src_tick  = source_select ? ext_tick : instr_tick;

  // prescaler terminal value: 0, 1, 3, 7
  wire [2:0] presc_last = (input_prescale_select == 2'h3) ? 3'h7 :
                          (input_prescale_select == 2'h2) ? 3'h3 :
                          (input_prescale_select == 2'h1) ? 3'h1 : 3'h0;
  // >= so a smaller ratio chosen mid-count does not run on to 7 first
  wire       presc_hit  = (presc >= presc_last);
  wire       cnt_tick   = counter_run && src_tick && presc_hit;

  // count writes (low byte, or high byte in byte mode) win over the increment; such a write never counts as a wrap
  wire       cnt_write  = wr_low || (wr_high && !wide_access_enable);
  wire       wrap       = cnt_tick && !cnt_write && (count == COUNT_MAX);

  // next count
  wire [15:0] count_inc = count + 16'h0001;
  wire [15:0] next_count =
      wr_low  ? (wide_access_enable ? {high_buffer, bus_req_i.wdata}
                                    : {count[15:8], bus_req_i.wdata}) :
      (wr_high && !wide_access_enable) ? {bus_req_i.wdata, count[7:0]} :
      cnt_tick ? count_inc : count;

  // pins: oscillator enable forces input and masks port reads
  wire [1:0] pin_levels = low_power_osc_enable ? 2'h0 : pin_s2;

  // read mux
  wire [7:0] ctl_read = {timer_control[7], secondary_clock_active, timer_control[5:0]};
  wire [7:0] high_read = wide_access_enable ? high_buffer : count[15:8];
  wire [7:0] next_rdata =
      !bus_req_i.re                           ? BYTE_ZERO :
      (bus_req_i.addr == REG_TIMER_CONTROL)   ? ctl_read :
      (bus_req_i.addr == REG_COUNT_LOW)       ? count[7:0] :
      (bus_req_i.addr == REG_COUNT_HIGH)      ? high_read :
      (bus_req_i.addr == REG_IRQ_STATUS)      ? {7'h00, overflow_flag} :
      (bus_req_i.addr == REG_IRQ_MASK)        ? {7'h00, overflow_irq_enable} :
      (bus_req_i.addr == REG_OSC_CONTROL)     ? oscillator_control :
      (bus_req_i.addr == REG_POWER_STATE)     ? {6'h00, 2'(pstate)} :
      {2'h0, pin_levels, pin_out_data, port_a_direction};

  // power-state sequencing
  always_comb begin
    next_pstate = pstate;
    unique case (pstate)
      PRIMARY_RUN: begin
        if (system_clock_select == SCS_SECONDARY) begin
          next_pstate = SECONDARY_RUN;
        end
      end
      SECONDARY_RUN: begin
        if (system_clock_select != SCS_SECONDARY) begin
          next_pstate = PRIMARY_RUN;
        end else if (sleep_exec_i && !idle_on_sleep) begin
          next_pstate = SECONDARY_IDLE;
        end
      end
      SECONDARY_IDLE: begin
        if (wake_i) begin
          next_pstate = SECONDARY_RUN;
        end
      end
      default: begin
        next_pstate = PRIMARY_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pin_s1   <= 2'h0;
      pin_s2   <= 2'h0;
      src_prev <= 1'b0;
    end else begin
      pin_s1   <= osc_pins_in_i;
      pin_s2   <= pin_s1;
      src_prev <= src_level;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      instr_div    <= 2'h0;
      sync_pending <= 1'b0;
    end else begin
      instr_div    <= instr_div + 2'h1;
      sync_pending <= !instr_tick && (sync_pending || src_rise);
    end
  end

  // prescaler clears on low-byte write only
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || wr_low) begin
      presc <= PRESC_ZERO;
    end else if (counter_run && src_tick) begin
      presc <= presc_hit ? PRESC_ZERO : presc + 3'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      count       <= COUNT_RESET;
      high_buffer <= BYTE_ZERO;
    end else begin
      count <= next_count;
      if (wr_high && wide_access_enable) begin
        high_buffer <= bus_req_i.wdata;
      end else if (rd_low && wide_access_enable) begin
        high_buffer <= count[15:8];
      end
    end
  end

  // overflow flag: set wins over the read-clear
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (rd_stat) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      timer_control       <= CONTROL_RESET;
      oscillator_control  <= OSC_CTL_RESET;
      overflow_irq_enable <= 1'b0;
      port_a_direction    <= PIN_DIR_RESET;
      pin_out_data        <= PIN_OUT_RESET;
      pstate              <= PRIMARY_RUN;
      rdata               <= BYTE_ZERO;
    end else begin
      pstate <= next_pstate;
      rdata  <= next_rdata;
      if (wr_ctl) begin
        timer_control <= bus_req_i.wdata;
      end
      if (wr_osc) begin
        oscillator_control <= bus_req_i.wdata;
      end
      if (wr_mask) begin
        overflow_irq_enable <= bus_req_i.wdata[0];
      end
      if (wr_pins) begin
        port_a_direction <= bus_req_i.wdata[PIN_DIR_LO_BIT +: 2];
        pin_out_data     <= bus_req_i.wdata[PIN_OUT_LO_BIT +: 2];
      end
    end
  end

  // outputs
  assign bus_rdata_o            = rdata;
  assign irq_o                  = overflow_flag && overflow_irq_enable;
  assign osc_running_o          = low_power_osc_enable;
  assign cpu_clk_secondary_o    = (pstate == SECONDARY_RUN);
  assign periph_clk_secondary_o = secondary_clock_active;
  assign cpu_halted_o           = (pstate == SECONDARY_IDLE);
  assign osc_pins_out_o         = pin_out_data;
  // direction 1 means input; oscillator forces both pins to input
  assign osc_pins_oe_n_o        = port_a_direction | {2{low_power_osc_enable}};

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_wrap_sets_flag: assert property (
    (cnt_tick && !cnt_write && count == COUNT_MAX) |=> (count == COUNT_RESET) && overflow_flag)
    else $error("wrap did not clear count or latch overflow flag");

  a_stopped_holds: assert property (
    (!counter_run && !bus_req_i.we) |=> $stable(count))
    else $error("count moved while stopped");

  a_irq_gated: assert property (
    (!overflow_irq_enable || !overflow_flag) |-> !irq_o)
    else $error("interrupt raised without enabled flag");

  a_wide_read_copy: assert property (
    (rd_low && wide_access_enable && !wr_high) |=> (high_buffer == $past(count[15:8])))
    else $error("low read did not latch high byte");

  a_wide_write_both: assert property (
    (wr_low && wide_access_enable) |=> (count == {$past(high_buffer), $past(bus_req_i.wdata)}))
    else $error("wide low write did not load both bytes");

  a_presc_clear: assert property (
    wr_low |=> (presc == PRESC_ZERO))
    else $error("prescaler not cleared by low write");

  a_osc_pins_input: assert property (
    low_power_osc_enable |-> (osc_pins_oe_n_o == 2'h3) && (pin_levels == 2'h0))
    else $error("oscillator pins driven or read nonzero");

  a_instr_spacing: assert property (
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction strobe not one in four");

  a_idle_entry: assert property (
    (pstate == SECONDARY_RUN && system_clock_select == SCS_SECONDARY && sleep_exec_i && !idle_on_sleep)
      |=> cpu_halted_o && periph_clk_secondary_o)
    else $error("sleep did not enter secondary idle");

  a_sec_status: assert property (
    (system_clock_select != SCS_SECONDARY && pstate != SECONDARY_IDLE) |=> !secondary_clock_active)
    else $error("secondary status stuck after leaving oscillator");

  a_div_by_one: assert property (
    (input_prescale_select == 2'h0 && counter_run && !source_select && instr_tick && !cnt_write)
      |=> (count == $past(count_inc)))
    else $error("1:1 prescale did not count each instruction cycle");

endmodule

`default_nettype wire

// [hw/timer_pkg.sv]
/*
  Shared constants and types for the sixteen-bit timer/counter: register
  indices, field positions, reset values, divider counts and the bus carrier.
  Assumes one system clock (Fosc) and a core-side register port of 8-bit data.
*/
package timer_pkg;

  // register indices on the core-side port
  localparam logic [2:0] REG_TIMER_CONTROL  = 3'h0;
  localparam logic [2:0] REG_COUNT_LOW      = 3'h1;
  localparam logic [2:0] REG_COUNT_HIGH     = 3'h2;
  localparam logic [2:0] REG_IRQ_STATUS     = 3'h3;
  localparam logic [2:0] REG_IRQ_MASK       = 3'h4;
  localparam logic [2:0] REG_OSC_CONTROL    = 3'h5;
  localparam logic [2:0] REG_POWER_STATE    = 3'h6;
  localparam logic [2:0] REG_PORT_PINS      = 3'h7;

  // timer_control field positions
  localparam int CTL_RUN_BIT       = 0;
  localparam int CTL_SRC_BIT       = 1;
  localparam int CTL_SYNC_BYP_BIT  = 2;
  localparam int CTL_OSC_EN_BIT    = 3;
  localparam int CTL_PRESC_LO_BIT  = 4;
  localparam int CTL_SEC_ACT_BIT   = 6;
  localparam int CTL_WIDE_BIT      = 7;

  // oscillator_control field positions
  localparam int OSC_SCS_LO_BIT    = 0;
  localparam int OSC_IDLE_BIT      = 7;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;

  // port_pins field positions: direction, output data, pin levels
  localparam int PIN_DIR_LO_BIT    = 0;
  localparam int PIN_OUT_LO_BIT    = 2;
  localparam int PIN_LVL_LO_BIT    = 4;

  // values after reset
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  OSC_CTL_RESET    = 8'h00;
  localparam logic [1:0]  PIN_DIR_RESET    = 2'h3;
  localparam logic [1:0]  PIN_OUT_RESET    = 2'h0;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;

  // instruction cycle is Fosc divided by four
  localparam int          FOSC_PER_INSTR   = 4;
  localparam logic [1:0]  INSTR_DIV_LAST   = 2'(FOSC_PER_INSTR - 1);
  localparam logic [2:0]  PRESC_ZERO       = 3'h0;

  typedef enum logic [1:0] {
    PRIMARY_RUN,
    SECONDARY_RUN,
    SECONDARY_IDLE
  } power_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_t;

endpackage

// [test/core_model.sv]
/*
  Core-side model: drives the register port and the power events.
  Assumes one clock and read data standing only in the cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module core_model
  import timer_pkg::*;
(
  // clock
  input  wire logic       mclk_i,
  // register port
  output reg_req_t        bus_req_o,
  input  wire logic [7:0] bus_rdata_i,
  // power events
  output logic            sleep_exec_o,
  output logic            wake_o
);
  initial begin
    bus_req_o    = '0;
    sleep_exec_o = 1'b0;
    wake_o       = 1'b0;
  end

  // one idle cycle after each strobe so no signal is set twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_req_o <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge mclk_i);
    bus_req_o.we <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus_req_o <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge mclk_i);
    bus_req_o.re <= 1'b0;
    @(posedge mclk_i);
    // read data stand in this cycle only; taken at its closing edge
    d = bus_rdata_i;
  endtask

  task automatic ev(input logic slp);
    if (slp) begin
      sleep_exec_o <= 1'b1;
    end else begin
      wake_o <= 1'b1;
    end
    @(posedge mclk_i);
    sleep_exec_o <= 1'b0;
    wake_o       <= 1'b0;
    @(posedge mclk_i);
  endtask
endmodule

`default_nettype wire

// [test/sixteen_bit_timer_counter_bench.sv]
/*
  Self-checking bench for the sixteen-bit timer/counter.
  Assumes the core model above and a 40 MHz clock on mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sixteen_bit_timer_counter_bench;
  import timer_pkg::*;
  logic       mclk_i;
  logic       resetn_i;
  reg_req_t   req;
  logic [7:0] rdata;
  logic [7:0] v;
  logic       slp;
  logic       wake;
  logic [1:0] ext;
  logic [1:0] pout;
  logic [1:0] oe_n;
  logic [1:0] pins;
  logic       osc_run;
  logic       cpu_sec;
  logic       per_sec;
  logic       halted;
  logic       irq;
  int         fails;
  int         samples_checked;
  int         cyc;

  // pin level: design drives where its enable is low
  assign pins = {oe_n[1] ? ext[1] : pout[1], oe_n[0] ? ext[0] : pout[0]};

  core_model core_model_i (
    .mclk_i       (mclk_i),
    .bus_req_o    (req),
    .bus_rdata_i  (rdata),
    .sleep_exec_o (slp),
    .wake_o       (wake)
  );

  sixteen_bit_timer_counter sixteen_bit_timer_counter_i (
    .mclk_i                 (mclk_i),
    .resetn_i               (resetn_i),
    .bus_req_i              (req),
    .bus_rdata_o            (rdata),
    .sleep_exec_i           (slp),
    .wake_i                 (wake),
    .osc_pins_in_i          (pins),
    .osc_pins_out_o         (pout),
    .osc_pins_oe_n_o        (oe_n),
    .osc_running_o          (osc_run),
    .cpu_clk_secondary_o    (cpu_sec),
    .periph_clk_secondary_o (per_sec),
    .cpu_halted_o           (halted),
    .irq_o                  (irq)
  );

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
    core_model_i.rd(a, v);
    chk(n, e, v);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    core_model_i.wr(a, d);
  endtask

  // slow edges, well above the synchroniser delay
  task automatic edges(input int b, input int n);
    repeat (n) begin
      ext[b] <= 1'b1;
      repeat (8) @(posedge mclk_i);
      ext[b] <= 1'b0;
      repeat (8) @(posedge mclk_i);
    end
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    resetn_i = 1'b0;
    ext      = 2'b00;
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    rc(REG_TIMER_CONTROL, CONTROL_RESET, "ctl_reset");
    rc(REG_PORT_PINS, 8'h03, "pins_reset");
    chk("irq_reset", 8'h00, 8'(irq));
    chk("osc_off", 8'h00, 8'(osc_run));
    // prescaler ratios; bypass bit toggled but must be ignored
    for (int p = 0; p < 4; p++) begin
      wr(REG_COUNT_HIGH, 8'h00);
      wr(REG_COUNT_LOW, 8'h00);
      wr(REG_TIMER_CONTROL, {2'b00, 2'(p), 1'b0, 1'(p), 2'b01});
      repeat (40 << p) @(posedge mclk_i);
      wr(REG_TIMER_CONTROL, 8'h00);
      core_model_i.rd(REG_COUNT_LOW, v);
      chk("prescale", 8'h01, 8'(v >= 9 && v <= 11));
      repeat (20) @(posedge mclk_i);
      rc(REG_COUNT_LOW, v, "held");
    end
    // external pin, synchronised and not
    for (int b = 0; b < 2; b++) begin
      wr(REG_COUNT_LOW, 8'h00);
      wr(REG_TIMER_CONTROL, {5'h00, 1'(b), 2'b11});
      edges(1, 5);
      repeat (8) @(posedge mclk_i);
      wr(REG_TIMER_CONTROL, 8'h00);
      rc(REG_COUNT_LOW, 8'h05, "ext_count");
    end
    // oscillator pins
    wr(REG_PORT_PINS, 8'h0C);
    chk("oe_port", 8'h00, 8'(oe_n));
    // driven levels need two cycles through the pin synchroniser
    repeat (2) @(posedge mclk_i);
    rc(REG_PORT_PINS, 8'h3C, "pins_out");
    wr(REG_TIMER_CONTROL, 8'h0B);
    repeat (50) @(posedge mclk_i);
    chk("oe_osc", 8'h03, 8'(oe_n));
    ext <= 2'b11;
    repeat (8) @(posedge mclk_i);
    rc(REG_PORT_PINS, 8'h0C, "pins_osc");
    ext <= 2'b00;
    repeat (8) @(posedge mclk_i);
    wr(REG_COUNT_HIGH, 8'h00);
    wr(REG_COUNT_LOW, 8'h00);
    edges(0, 3);
    edges(1, 2);
    rc(REG_COUNT_LOW, 8'h03, "osc_count");
    // power states
    wr(REG_OSC_CONTROL, 8'h01);
    repeat (2) @(posedge mclk_i);
    chk("cpu_sec", 8'h01, 8'(cpu_sec));
    rc(REG_POWER_STATE, 8'h01, "sec_run");
    rc(REG_TIMER_CONTROL, 8'h4B, "sec_active");
    core_model_i.ev(1'b1);
    rc(REG_POWER_STATE, 8'h02, "sec_idle");
    chk("halted", 8'h01, 8'(halted));
    chk("cpu_idle", 8'h00, 8'(cpu_sec));
    chk("per_sec", 8'h01, 8'(per_sec));
    chk("osc_idle", 8'h01, 8'(osc_run));
    core_model_i.ev(1'b0);
    rc(REG_POWER_STATE, 8'h01, "woken");
    wr(REG_OSC_CONTROL, 8'h81);
    core_model_i.ev(1'b1);
    rc(REG_POWER_STATE, 8'h01, "idle_set");
    wr(REG_OSC_CONTROL, 8'h00);
    repeat (2) @(posedge mclk_i);
    rc(REG_TIMER_CONTROL, 8'h0B, "primary");
    rc(REG_POWER_STATE, 8'h00, "primary_st");
    // byte mode, then buffered 16-bit access and overflow
    wr(REG_TIMER_CONTROL, 8'h00);
    wr(REG_COUNT_HIGH, 8'h34);
    rc(REG_COUNT_HIGH, 8'h34, "byte_high");
    wr(REG_TIMER_CONTROL, 8'h80);
    wr(REG_COUNT_HIGH, 8'hFF);
    wr(REG_COUNT_LOW, 8'hFD);
    rc(REG_COUNT_LOW, 8'hFD, "wide_low");
    rc(REG_COUNT_HIGH, 8'hFF, "wide_high");
    wr(REG_COUNT_HIGH, 8'h12);
    rc(REG_COUNT_LOW, 8'hFD, "wide_low2");
    rc(REG_COUNT_HIGH, 8'hFF, "live_high");
    wr(REG_TIMER_CONTROL, 8'h81);
    repeat (20) @(posedge mclk_i);
    wr(REG_TIMER_CONTROL, 8'h80);
    core_model_i.rd(REG_COUNT_LOW, v);
    rc(REG_COUNT_HIGH, 8'h00, "wrapped");
    chk("irq_masked", 8'h00, 8'(irq));
    wr(REG_IRQ_MASK, 8'h01);
    chk("irq_on", 8'h01, 8'(irq));
    rc(REG_IRQ_STATUS, 8'h01, "flag");
    chk("irq_off", 8'h00, 8'(irq));
    rc(REG_IRQ_STATUS, 8'h00, "flag_clr");
    give_verdict();
  end
endmodule

`default_nettype wire
